// ==== core/svm_delay.sv ====
// Qualification counter: output rises once input has held high for a set count.
`timescale 1ns/1ps
module svm_delay #(
	parameter int unsigned COUNT = 12000
) (
	input  wire logic clk_sys,
	input  wire logic arst_n,
	input  wire logic din,
	output logic      done
);
	localparam int unsigned CW = $clog2(COUNT + 1);
	localparam logic [CW-1:0] LAST = CW'(COUNT - 1);
	logic [CW-1:0] cnt_ff;

	// Any drop of the input restarts the count, so slow supply wobble does not accumulate.
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			cnt_ff <= '0;
			done   <= 1'b0;
		end else if (!din) begin
			cnt_ff <= '0;
			done   <= 1'b0;
		end else if (cnt_ff != LAST) begin
			cnt_ff <= cnt_ff + CW'(1);
			done   <= 1'b0;
		end else begin
			done   <= 1'b1;
		end
	end
endmodule

// ==== core/svm_pkg.sv ====
// Package with register map, field layout and timing constants of the supply monitor.
package svm_pkg;
	localparam int unsigned ADDR_W        = 4;
	localparam logic [3:0]  OFS_CONTROL   = 4'h0;
	localparam logic [3:0]  OFS_IRQ_STAT  = 4'h1;
	localparam logic [3:0]  OFS_IRQ_MASK  = 4'h2;
	localparam int unsigned BIT_THR_LSB   = 0;
	localparam int unsigned BIT_THR_MSB   = 2;
	localparam int unsigned BIT_ENABLE    = 4;
	localparam int unsigned BIT_FLAG      = 5;
	localparam int unsigned BIT_IRQ_LOW   = 0;
	localparam int unsigned BIT_IRQ_READY = 1;
	localparam logic [7:0]  RST_CONTROL   = 8'h00;
	localparam logic [1:0]  RST_IRQ       = 2'h0;
	localparam int unsigned CLK_MHZ       = 200;
	// Settling time after enable before the flag is trusted, in microseconds.
	localparam int unsigned SETTLE_US     = 150;
	localparam int unsigned SETTLE_CYC    = SETTLE_US * CLK_MHZ;
	// Low-supply persistence before interrupt request, in microseconds.
	localparam int unsigned IRQ_DELAY_US  = 60;
	localparam int unsigned IRQ_DELAY_CYC = IRQ_DELAY_US * CLK_MHZ;

	// Trip level in millivolts for each threshold code, code 111 is the top of range.
	localparam logic [11:0] LEVEL_MV [8] = '{12'h708, 12'h7d0, 12'h960, 12'ha8c,
		12'hbb8, 12'hce4, 12'he10, 12'hfa0};

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [7:0]        wdata;
		logic              wr;
		logic              rd;
	} svm_bus_t;

	typedef struct packed {
		logic       enable;
		logic [2:0] thr;
	} svm_ctrl_t;
endpackage

// ==== core/svm_sync.sv ====
// Two-flop synchroniser for a level arriving from outside the clock domain.
`timescale 1ns/1ps
module svm_sync (
	input  wire logic clk_sys,
	input  wire logic arst_n,
	input  wire logic din,
	output logic      dout
);
	logic meta_ff;

	// Only the second flop is read by downstream logic.
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			meta_ff <= 1'b0;
			dout    <= 1'b0;
		end else begin
			meta_ff <= din;
			dout    <= meta_ff;
		end
	end
endmodule

// ==== core/svm_top.sv ====
// Supply monitor control register, comparator qualification and interrupt logic.
//
// The register offsets and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
module svm_top
	import svm_pkg::*;
#(
	parameter int unsigned SETTLE_CYCLES = SETTLE_CYC,
	parameter int unsigned IRQ_CYCLES    = IRQ_DELAY_CYC
) (
	input  wire logic              clk_sys,
	input  wire logic              arst_n,
	input  wire logic [ADDR_W-1:0] busAddr,
	input  wire logic [7:0]        busWdata,
	input  wire logic              busWr,
	input  wire logic              busRd,
	output logic [7:0]             busRdata_ff,
	input  wire logic              sleepMode,
	input  wire logic              cmpBelow,
	output logic                   detectorPowerOn_ff,
	output logic [2:0]             thresholdCode_ff,
	output logic [11:0]            tripLevelMv_ff,
	output logic                   lowSupplyIrqFlag_ff,
	output logic                   irq_ff
);
	svm_bus_t  bus;
	svm_ctrl_t ctrl_ff;
	logic      cmpSync;
	logic      settled;
	logic      lowSupplyFlag_ff;
	logic      lowQualified;
	logic      lowQualified_d_ff;
	logic      ready_d_ff;
	logic [1:0] irqStat_ff;
	logic [1:0] irqMask_ff;
	logic [1:0] evt;
	logic [1:0] nxt_irqStat;
	logic [7:0] nxt_rdata;
	logic       detOn;

	assign bus = '{addr: busAddr, wdata: busWdata, wr: busWr, rd: busRd};

	// Sleep overrides the enable bit so the analogue part is powered down on the first clock edge after sleep is raised.
	assign detOn = ctrl_ff.enable & ~sleepMode;

	// Comparator output comes from the analogue domain and must be synchronised.
	svm_sync u_sync (
		.clk_sys (clk_sys),
		.arst_n  (arst_n),
		.din     (cmpBelow),
		.dout    (cmpSync)
	);

	// Flag is not trusted until the comparator has had time to settle after power-up.
	svm_delay #(.COUNT(SETTLE_CYCLES)) u_settle (
		.clk_sys (clk_sys),
		.arst_n  (arst_n),
		.din     (detOn),
		.done    (settled)
	);

	// Interrupt qualification needs the low condition to persist for the fixed delay.
	svm_delay #(.COUNT(IRQ_CYCLES)) u_irqdly (
		.clk_sys (clk_sys),
		.arst_n  (arst_n),
		.din     (lowSupplyFlag_ff),
		.done    (lowQualified)
	);

	// Control register; only enable and threshold are writable.
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_ff <= '{enable: RST_CONTROL[BIT_ENABLE],
				thr: RST_CONTROL[BIT_THR_MSB:BIT_THR_LSB]};
		end else if (bus.wr && bus.addr == OFS_CONTROL) begin
			ctrl_ff.enable <= bus.wdata[BIT_ENABLE];
			ctrl_ff.thr    <= bus.wdata[BIT_THR_MSB:BIT_THR_LSB];
		end
	end

	// Low-supply flag follows the comparator only while the detector runs.
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			lowSupplyFlag_ff <= 1'b0;
		end else if (!detOn) begin
			lowSupplyFlag_ff <= 1'b0;
		end else if (settled) begin
			lowSupplyFlag_ff <= cmpSync;
		end
	end

	// Drive the analogue side: power and selected trip level.
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			detectorPowerOn_ff <= 1'b0;
			thresholdCode_ff   <= 3'h0;
			tripLevelMv_ff     <= 12'h000;
		end else begin
			detectorPowerOn_ff <= detOn;
			thresholdCode_ff   <= ctrl_ff.thr;
			tripLevelMv_ff     <= LEVEL_MV[ctrl_ff.thr];
		end
	end

	// Rising edges of qualified low supply and of detector ready are the events.
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			lowQualified_d_ff <= 1'b0;
			ready_d_ff        <= 1'b0;
		end else begin
			lowQualified_d_ff <= lowQualified;
			ready_d_ff        <= settled;
		end
	end

	assign evt[BIT_IRQ_LOW]   = lowQualified & ~lowQualified_d_ff;
	assign evt[BIT_IRQ_READY] = settled & ~ready_d_ff;

	// Write-one-to-clear, a new event in the same cycle wins over the clear.
	always_comb begin
		nxt_irqStat = irqStat_ff;
		if (bus.wr && bus.addr == OFS_IRQ_STAT) begin
			nxt_irqStat = irqStat_ff & ~bus.wdata[1:0];
		end
		nxt_irqStat = nxt_irqStat | evt;
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			irqStat_ff <= RST_IRQ;
		end else begin
			irqStat_ff <= nxt_irqStat;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			irqMask_ff <= RST_IRQ;
		end else if (bus.wr && bus.addr == OFS_IRQ_MASK) begin
			irqMask_ff <= bus.wdata[1:0];
		end
	end

	// Outputs registered from next-state so they track status without extra lag.
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			irq_ff              <= 1'b0;
			lowSupplyIrqFlag_ff <= 1'b0;
		end else begin
			irq_ff              <= |(nxt_irqStat & irqMask_ff);
			lowSupplyIrqFlag_ff <= nxt_irqStat[BIT_IRQ_LOW];
		end
	end

	// Read mux; unused bits and unmapped addresses read as zero.
	always_comb begin
		nxt_rdata = 8'h00;
		unique case (bus.addr)
			OFS_CONTROL: begin
				nxt_rdata[BIT_THR_MSB:BIT_THR_LSB] = ctrl_ff.thr;
				nxt_rdata[BIT_ENABLE]              = ctrl_ff.enable;
				nxt_rdata[BIT_FLAG]                = lowSupplyFlag_ff;
			end
			OFS_IRQ_STAT: nxt_rdata[1:0] = irqStat_ff;
			OFS_IRQ_MASK: nxt_rdata[1:0] = irqMask_ff;
			default:      nxt_rdata = 8'h00;
		endcase
	end

	// Read data valid only in the cycle after the strobe, zero otherwise.
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			busRdata_ff <= 8'h00;
		end else if (bus.rd) begin
			busRdata_ff <= nxt_rdata;
		end else begin
			busRdata_ff <= 8'h00;
		end
	end
endmodule

// ==== verification/supply_voltage_monitor_test.sv ====
// Self-checking bench for the supply monitor register logic.
`timescale 1ns/1ps
module supply_voltage_monitor_test
	import svm_pkg::*;
;
	typedef struct packed {
		logic [7:0]  wd;
		logic [7:0]  rd;
		logic [11:0] mv;
	} svm_row_t;
	logic              clk_sys = 1'b0;
	logic              arst_n = 1'b0;
	logic [ADDR_W-1:0] busAddr = '0;
	logic [7:0]        busWdata = 8'h00;
	logic              busWr = 1'b0;
	logic              busRd = 1'b0;
	logic              sleepMode = 1'b0;
	logic              cmpBelow = 1'b0;
	logic [7:0]        busRdata_ff;
	logic [7:0]        v;
	logic              pwr, irqFlag, irq;
	logic [2:0]        code;
	logic [11:0]       mv;
	int                badCount = 0;
	int                checkCount = 0;
	// Junk in bits 7, 6, 5 and 3 of every write must be dropped.
	svm_row_t          rows [8] = '{'{8'he9, 8'h01, 12'h7d0}, '{8'hea, 8'h02, 12'h960},
		'{8'heb, 8'h03, 12'ha8c}, '{8'hec, 8'h04, 12'hbb8}, '{8'hed, 8'h05, 12'hce4},
		'{8'hee, 8'h06, 12'he10}, '{8'hef, 8'h07, 12'hfa0}, '{8'he8, 8'h00, 12'h708}};

	svm_top #(.SETTLE_CYCLES(4), .IRQ_CYCLES(3)) u_svm_top (.clk_sys(clk_sys), .arst_n(arst_n),
		.busAddr(busAddr), .busWdata(busWdata), .busWr(busWr), .busRd(busRd),
		.busRdata_ff(busRdata_ff), .sleepMode(sleepMode), .cmpBelow(cmpBelow),
		.detectorPowerOn_ff(pwr), .thresholdCode_ff(code), .tripLevelMv_ff(mv),
		.lowSupplyIrqFlag_ff(irqFlag), .irq_ff(irq));

	// The 200 MHz system clock.
	always #2.5 clk_sys = ~clk_sys;

	task automatic chk(input logic [11:0] seen, input logic [11:0] exp, input string what);
		checkCount++;
		if (seen !== exp) begin
			badCount++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		busAddr <= a;
		busWdata <= d;
		busWr <= 1'b1;
		@(posedge clk_sys);
		busWr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe, so sample just past that edge.
	task automatic rd(input logic [3:0] a);
		@(posedge clk_sys);
		busAddr <= a;
		busRd <= 1'b1;
		@(posedge clk_sys);
		busRd <= 1'b0;
		#1 v = busRdata_ff;
	endtask
	task automatic endOfTest;
		$display("checks %0d mismatches %0d", checkCount, badCount);
		if (badCount == 0 && checkCount > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask

	// Main sequence: reset values, code table, then the flag, interrupt and power cases.
	initial begin
		tick(10);
		arst_n <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			rd(i == 3 ? 4'hf : i[3:0]);
			chk(v, 8'h00, "reset read");
		end
		foreach (rows[i]) begin
			wr(OFS_CONTROL, rows[i].wd);
			rd(OFS_CONTROL);
			chk(v, rows[i].rd, "control");
			chk(code, rows[i].rd[2:0], "code");
			chk(mv, rows[i].mv, "trip level");
		end
		wr(OFS_CONTROL, 8'h33);
		tick(12);
		rd(OFS_CONTROL);
		chk(v, 8'h13, "flag low");
		chk(pwr, 1'b1, "power on");
		cmpBelow <= 1'b1;
		for (int n = 0; irqFlag !== 1'b1; n++) begin
			if (n == 40) begin
				badCount++;
				endOfTest();
			end
			tick(1);
		end
		rd(OFS_CONTROL);
		chk(v, 8'h33, "flag high");
		chk(irq, 1'b0, "masked irq");
		// Both the settle event and the qualified low event must now be pending.
		rd(OFS_IRQ_STAT);
		chk(v, 8'h03, "status pending");
		wr(OFS_IRQ_MASK, 8'h01);
		tick(1);
		chk(irq, 1'b1, "irq");
		cmpBelow <= 1'b0;
		tick(6);
		wr(OFS_IRQ_STAT, 8'h01);
		tick(1);
		chk(irqFlag, 1'b0, "cleared");
		chk(irq, 1'b0, "irq off");
		rd(OFS_IRQ_STAT);
		chk(v, 8'h02, "status after clear");
		cmpBelow <= 1'b1;
		sleepMode <= 1'b1;
		tick(3);
		chk(pwr, 1'b0, "sleep power");
		rd(OFS_CONTROL);
		chk(v, 8'h13, "sleep flag");
		sleepMode <= 1'b0;
		wr(OFS_CONTROL, 8'h03);
		tick(2);
		chk(pwr, 1'b0, "disabled");
		rd(OFS_CONTROL);
		chk(v, 8'h03, "off flag");
		// Mid-run reset must bring power, code, trip level, irq, control and mask back to zero.
		arst_n <= 1'b0;
		cmpBelow <= 1'b0;
		tick(2);
		chk(pwr, 1'b0, "reset power");
		chk(code, 3'h0, "reset code");
		chk(mv, 12'h000, "reset level");
		chk(irq, 1'b0, "reset irq");
		arst_n <= 1'b1;
		rd(OFS_CONTROL);
		chk(v, 8'h00, "control after reset");
		rd(OFS_IRQ_MASK);
		chk(v, 8'h00, "mask after reset");
		// The settle event and a clear of its bit land on the same edge; the set must win.
		wr(OFS_CONTROL, 8'h10);
		tick(3);
		wr(OFS_IRQ_STAT, 8'h02);
		rd(OFS_IRQ_STAT);
		chk(v, 8'h02, "set beats clear");
		endOfTest();
	end
endmodule

// ==== verification/svm_checker.sv ====
// Port-level assertions for the supply monitor.
`timescale 1ns/1ps
module svm_checker
	import svm_pkg::*;
#(
	parameter int unsigned IRQ_CYCLES = 3
) (
	input wire logic              clk_sys,
	input wire logic              arst_n,
	input wire logic [ADDR_W-1:0] busAddr,
	input wire logic [7:0]        busWdata,
	input wire logic              busWr,
	input wire logic              busRd,
	input wire logic [7:0]        busRdata_ff,
	input wire logic              sleepMode,
	input wire logic              cmpBelow,
	input wire logic              detectorPowerOn_ff,
	input wire logic [2:0]        thresholdCode_ff,
	input wire logic              lowSupplyIrqFlag_ff
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	// Control register strobes, so the properties stay short.
	wire rdCtl = busRd && busAddr == OFS_CONTROL;
	wire wrCtl = busWr && busAddr == OFS_CONTROL;
	property p_rsvd; $past(rdCtl) |-> busRdata_ff[7:6] == 2'h0 && !busRdata_ff[3]; endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
	property p_thr; $past(wrCtl) && !busWr |=> thresholdCode_ff == $past(busWdata[2:0], 2); endproperty
	a_thr: assert property (p_thr) else $error("code not taken");
	property p_en; $past(wrCtl && !busWdata[BIT_ENABLE]) |=> !detectorPowerOn_ff; endproperty
	a_en: assert property (p_en) else $error("detector stays on");
	property p_sleep; $past(sleepMode) |-> !detectorPowerOn_ff; endproperty
	a_sleep: assert property (p_sleep) else $error("on while asleep");
	// A flag reading one needs a powered detector in the cycles before.
	property p_pwr; $past(rdCtl) && busRdata_ff[BIT_FLAG] |-> $past(detectorPowerOn_ff)
		|| $past(detectorPowerOn_ff, 2) || $past(detectorPowerOn_ff, 3); endproperty
	a_pwr: assert property (p_pwr) else $error("flag while off");
	property p_low; $past(rdCtl) && busRdata_ff[BIT_FLAG] |-> $past(cmpBelow, 2)
		|| $past(cmpBelow, 3) || $past(cmpBelow, 4) || $past(cmpBelow, 5); endproperty
	a_low: assert property (p_low) else $error("flag without low supply");
	property p_dly; $rose(lowSupplyIrqFlag_ff) |-> $past(cmpBelow, IRQ_CYCLES + 2); endproperty
	a_dly: assert property (p_dly) else $error("request too early");
	property p_clr; $fell(lowSupplyIrqFlag_ff) |-> $past(busWr && busWdata[0]); endproperty
	a_clr: assert property (p_clr) else $error("request dropped alone");
endmodule

bind svm_top svm_checker #(.IRQ_CYCLES(IRQ_CYCLES)) u_svm_checker (.clk_sys(clk_sys),
	.arst_n(arst_n), .busAddr(busAddr), .busWdata(busWdata), .busWr(busWr), .busRd(busRd),
	.busRdata_ff(busRdata_ff), .sleepMode(sleepMode), .cmpBelow(cmpBelow),
	.detectorPowerOn_ff(detectorPowerOn_ff), .thresholdCode_ff(thresholdCode_ff),
	.lowSupplyIrqFlag_ff(lowSupplyIrqFlag_ff));
